//--- cid_pkg.sv
/*
 * cid_pkg: constants, opcode field codes, decoded-instruction carrier and
 * register map for the core instruction decoder.
 * Assumes a 32-bit classic Wishbone slave with byte addresses.
 */
`default_nettype none

package cid_pkg;

    localparam int          INSTR_W          = 14;
    localparam int          WB_AW            = 8;
    localparam int          WB_DW            = 32;

    // register map, byte addresses
    localparam logic [7:0]  ADDR_INSTR       = 8'h00;
    localparam logic [7:0]  ADDR_COND        = 8'h04;
    localparam logic [7:0]  ADDR_DECODE      = 8'h08;
    localparam logic [7:0]  ADDR_STATUS      = 8'h0C;

    // condition register bits
    localparam int          COND_ZERO        = 0;
    localparam int          COND_BIT         = 1;
    localparam int          COND_PTR0_MSB    = 2;
    localparam int          COND_PTR1_MSB    = 3;
    localparam int          COND_W           = 4;

    // decode register fields
    localparam int          DEC_FLAGS_LO     = 5;
    localparam int          DEC_CYC_LO       = 10;
    localparam int          DEC_SKIP_BIT     = 12;
    localparam int          DEC_IND_BIT      = 13;

    // one instruction cycle spans four core clocks
    localparam int          ICYCLE_CLKS      = 4;
    localparam logic [1:0]  QUARTER_LAST     = 2'(ICYCLE_CLKS - 1);
    localparam logic [1:0]  CYC_ONE          = 2'h1;

    // opcode group and field codes
    localparam logic [1:0]  GRP_FILE         = 2'h0;
    localparam logic [1:0]  GRP_BIT          = 2'h1;
    localparam logic [1:0]  GRP_LIT          = 2'h3;
    localparam logic [3:0]  NIB_DEC_SKIP     = 4'hB;
    localparam logic [3:0]  NIB_INC_SKIP     = 4'hF;
    localparam logic [3:0]  NIB_INHERENT     = 4'h0;
    localparam logic [1:0]  BIT_CLR          = 2'h0;
    localparam logic [1:0]  BIT_SET          = 2'h1;
    localparam logic [1:0]  BIT_TST_CLR      = 2'h2;
    localparam logic [1:0]  BIT_TST_SET      = 2'h3;
    localparam logic [3:0]  NIB_OR_LIT       = 4'h8;
    localparam logic [3:0]  NIB_RET_LIT      = 4'h4;
    localparam logic [3:0]  NIB_SUB_LIT      = 4'hC;
    localparam logic [3:0]  NIB_XOR_LIT      = 4'hA;
    localparam logic [3:0]  NIB_PTR_PCU      = 4'h1;
    localparam logic [3:0]  NIB_INDEXED      = 4'hF;
    localparam logic [7:0]  LOW_BRANCH_ACC   = 8'h0B;
    localparam logic [7:0]  LOW_CALL_ACC     = 8'h0A;
    localparam logic [7:0]  LOW_INT_RET      = 8'h09;
    localparam logic [7:0]  LOW_SUB_RET      = 8'h08;
    localparam logic [7:0]  LOW_WDT_CLR      = 8'h64;
    localparam logic [7:0]  LOW_NOP          = 8'h00;
    localparam logic [7:0]  LOW_SOFT_RESET   = 8'h01;
    localparam logic [7:0]  LOW_STANDBY      = 8'h63;
    localparam logic [4:0]  PFX_DIR_LOAD     = 5'h0C;
    localparam logic [4:0]  PFX_IND_READ     = 5'h02;
    localparam logic [4:0]  PFX_IND_WRITE    = 5'h03;
    localparam logic [5:0]  INDIRECT_DATA_PORT_PAGE        = 6'h00;
    localparam int          PTR_MM_BIT       = 2;
    localparam int          PTR_IDX_BIT      = 6;

    // status flag mask bits: carry, digit carry, zero, timeout, powerdown
    localparam logic [4:0]  FLG_NONE         = 5'h00;
    localparam logic [4:0]  FLG_Z            = 5'h04;
    localparam logic [4:0]  FLG_CDCZ         = 5'h07;
    localparam logic [4:0]  FLG_TO_PD        = 5'h18;

    typedef enum logic [4:0] {
        OP_OTHER,
        OP_NOP,
        OP_SOFT_RESET,
        OP_DECREMENT_SKIP_ZERO,
        OP_INCREMENT_SKIP_ZERO,
        OP_BIT_CLEAR,
        OP_BIT_SET,
        OP_BIT_TEST_SKIP_CLEAR,
        OP_BIT_TEST_SKIP_SET,
        OP_OR_LITERAL,
        OP_SUBTRACT_FROM_LITERAL,
        OP_XOR_LITERAL,
        OP_LOAD_PC_UPPER,
        OP_RETURN_LITERAL,
        OP_RELATIVE_BRANCH_ACC,
        OP_CALL_VIA_ACCUMULATOR,
        OP_INTERRUPT_RETURN,
        OP_SUBROUTINE_RETURN,
        OP_WATCHDOG_CLEAR,
        OP_STANDBY,
        OP_DIRECTION_LOAD,
        OP_POINTER_ADD,
        OP_INDIRECT_READ_MOD,
        OP_INDIRECT_READ_IDX,
        OP_INDIRECT_WRITE_MOD,
        OP_INDIRECT_WRITE_IDX
    } cid_op_type;

    typedef enum {
        ST_IDLE,
        ST_RUN
    } cid_state_type;

    typedef struct packed {
        logic [1:0] grp;
        logic [1:0] nib_hi;
        logic [1:0] nib_lo;
        logic       sel7;
        logic [6:0] low7;
    } cid_word_type;

    typedef struct packed {
        cid_op_type op;
        logic       dest_file;
        logic [6:0] file_addr;
        logic [2:0] bit_idx;
        logic [7:0] literal;
        logic       ptr_sel;
        logic [1:0] mod_mode;
        logic [4:0] flags;
        logic       uses_indirect;
        logic       changes_pc;
        logic       may_skip;
    } cid_dec_type;

endpackage : cid_pkg

`default_nettype wire

//--- cid_decoder.sv
/*
 * cid_decoder: decodes one 14-bit instruction word, works out its length
 * in instruction cycles and paces it at four core clocks per cycle.
 * Assumes a classic Wishbone slave port; the word and the datapath condition
 * bits (zero result, tested bit, pointer msbs) are written by software.
 */
// Added by the designer: the Wishbone register port and the placing of the registers.
`default_nettype none

module cid_decoder
    import cid_pkg::*;
(
    input  wire logic              core_clk_i,
    input  wire logic              arst_n_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [WB_AW-1:0]  wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [WB_DW-1:0]  wb_dat_i,
    output logic      [WB_DW-1:0]  wb_dat_o,
    output logic                   wb_ack_o,
    output cid_dec_type            dec_o,
    output logic                   busy_o,
    output logic                   nop_phase_o
);

    function automatic cid_dec_type cid_decode(input logic [INSTR_W-1:0] word);
        cid_word_type w;
        cid_dec_type  d;
        logic [3:0]   nib;
        w               = cid_word_type'(word);
        nib             = {w.nib_hi, w.nib_lo};
        d               = '0;
        d.op            = OP_OTHER;
        d.dest_file     = w.sel7;
        d.file_addr     = w.low7;
        d.bit_idx       = {w.nib_lo, w.sel7};
        d.literal       = {w.sel7, w.low7};
        d.ptr_sel       = w.low7[PTR_MM_BIT];
        d.mod_mode      = w.low7[1:0];
        unique case (w.grp)
            GRP_FILE:
            begin
                if (nib == NIB_DEC_SKIP)
                begin
                    d.op        = OP_DECREMENT_SKIP_ZERO;
                    d.may_skip  = 1'b1;
                end
                else if (nib == NIB_INC_SKIP)
                begin
                    d.op        = OP_INCREMENT_SKIP_ZERO;
                    d.may_skip  = 1'b1;
                end
                else if (nib == NIB_INHERENT)
                begin
                    if (d.literal == LOW_BRANCH_ACC)
                    begin
                        d.op         = OP_RELATIVE_BRANCH_ACC;
                        d.changes_pc = 1'b1;
                    end
                    else if (d.literal == LOW_CALL_ACC)
                    begin
                        d.op         = OP_CALL_VIA_ACCUMULATOR;
                        d.changes_pc = 1'b1;
                    end
                    else if (d.literal == LOW_INT_RET)
                    begin
                        d.op         = OP_INTERRUPT_RETURN;
                        d.changes_pc = 1'b1;
                    end
                    else if (d.literal == LOW_SUB_RET)
                    begin
                        d.op         = OP_SUBROUTINE_RETURN;
                        d.changes_pc = 1'b1;
                    end
                    else if (d.literal == LOW_WDT_CLR)
                    begin
                        d.op    = OP_WATCHDOG_CLEAR;
                        d.flags = FLG_TO_PD;
                    end
                    else if (d.literal == LOW_STANDBY)
                    begin
                        d.op    = OP_STANDBY;
                        d.flags = FLG_TO_PD;
                    end
                    else if (d.literal == LOW_NOP)
                        d.op    = OP_NOP;
                    else if (d.literal == LOW_SOFT_RESET)
                        d.op    = OP_SOFT_RESET;
                    else if (d.literal[7:3] == PFX_DIR_LOAD)
                        d.op    = OP_DIRECTION_LOAD;
                    else if (d.literal[7:3] == PFX_IND_READ)
                    begin
                        d.op            = OP_INDIRECT_READ_MOD;
                        d.flags         = FLG_Z;
                        d.uses_indirect = 1'b1;
                    end
                    else if (d.literal[7:3] == PFX_IND_WRITE)
                    begin
                        d.op            = OP_INDIRECT_WRITE_MOD;
                        d.uses_indirect = 1'b1;
                    end
                end
                // skip-op file operand in the indirect data port page
                if (d.may_skip && w.low7[6:1] == INDIRECT_DATA_PORT_PAGE)
                begin
                    d.uses_indirect = 1'b1;
                    d.ptr_sel       = w.low7[0];
                end
            end
            GRP_BIT:
            begin
                unique case (w.nib_hi)
                    BIT_CLR:     d.op = OP_BIT_CLEAR;
                    BIT_SET:     d.op = OP_BIT_SET;
                    BIT_TST_CLR: d.op = OP_BIT_TEST_SKIP_CLEAR;
                    BIT_TST_SET: d.op = OP_BIT_TEST_SKIP_SET;
                endcase
                d.may_skip = w.nib_hi[1];
                d.dest_file = 1'b1;
                if (w.low7[6:1] == INDIRECT_DATA_PORT_PAGE)
                begin
                    d.uses_indirect = 1'b1;
                    d.ptr_sel       = w.low7[0];
                end
            end
            GRP_LIT:
            begin
                d.ptr_sel = w.low7[PTR_IDX_BIT];
                if (nib == NIB_OR_LIT)
                begin
                    d.op    = OP_OR_LITERAL;
                    d.flags = FLG_Z;
                end
                else if (nib == NIB_SUB_LIT)
                begin
                    d.op    = OP_SUBTRACT_FROM_LITERAL;
                    d.flags = FLG_CDCZ;
                end
                else if (nib == NIB_XOR_LIT)
                begin
                    d.op    = OP_XOR_LITERAL;
                    d.flags = FLG_Z;
                end
                else if (nib == NIB_RET_LIT)
                begin
                    d.op         = OP_RETURN_LITERAL;
                    d.changes_pc = 1'b1;
                end
                else if (nib == NIB_PTR_PCU)
                begin
                    // upper bit of the low byte picks latch load or pointer add
                    d.op      = w.sel7 ? OP_LOAD_PC_UPPER : OP_POINTER_ADD;
                    d.literal = w.sel7 ? {1'b0, w.low7} : {2'h0, w.low7[5:0]};
                end
                else if (nib == NIB_INDEXED)
                begin
                    d.op            = w.sel7 ? OP_INDIRECT_WRITE_IDX
                                             : OP_INDIRECT_READ_IDX;
                    d.flags         = w.sel7 ? FLG_NONE : FLG_Z;
                    d.literal       = {2'h0, w.low7[5:0]};
                    d.uses_indirect = 1'b1;
                end
            end
            default: d.op = OP_OTHER;
        endcase
        return d;
    endfunction : cid_decode

    cid_state_type      state_reg,   state_next;
    cid_dec_type        dec_reg,     dec_next;
    logic [INSTR_W-1:0] instr_reg,   instr_next;
    logic [COND_W-1:0]  cond_reg,    cond_next;
    logic [1:0]         total_reg,   total_next;
    logic [1:0]         remain_reg,  remain_next;
    logic [1:0]         quarter_reg, quarter_next;
    logic               skip_reg,    skip_next;
    logic               busy_reg,    busy_next;
    logic               nop_reg,     nop_next;
    logic               ack_reg,     ack_next;
    logic [WB_DW-1:0]   rdat_reg,    rdat_next;

    logic               wr_en;
    logic               start;
    logic               ptr_msb;
    logic               skip_true;
    cid_dec_type        dec_new;

    // write takes effect only at the edge that carries the ack
    assign wr_en   = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
    assign start   = wr_en && wb_adr_i == ADDR_INSTR && (|wb_sel_i[1:0])
                     && state_reg == ST_IDLE;
    assign dec_new = cid_decode(instr_next);
    assign ptr_msb = dec_new.ptr_sel ? cond_next[COND_PTR1_MSB] : cond_next[COND_PTR0_MSB];

    always_comb
    begin
        unique case (dec_new.op)
            OP_DECREMENT_SKIP_ZERO,
            OP_INCREMENT_SKIP_ZERO: skip_true = cond_next[COND_ZERO];
            OP_BIT_TEST_SKIP_CLEAR: skip_true = !cond_next[COND_BIT];
            OP_BIT_TEST_SKIP_SET:   skip_true = cond_next[COND_BIT];
            default:                skip_true = 1'b0;
        endcase
    end

    // the word and condition writes sit in their own process so the decode of
    // instr_next feeds the state logic without looping back into it
    always_comb
    begin
        instr_next = instr_reg;
        cond_next  = cond_reg;
        if (wr_en && wb_adr_i == ADDR_COND && wb_sel_i[0])
            cond_next = wb_dat_i[COND_W-1:0];
        // a word written while busy is dropped so the running one keeps its timing
        if (start)
        begin
            if (wb_sel_i[0])
                instr_next[7:0] = wb_dat_i[7:0];
            if (wb_sel_i[1])
                instr_next[INSTR_W-1:8] = wb_dat_i[INSTR_W-1:8];
        end
    end

    always_comb
    begin
        state_next   = state_reg;
        dec_next     = dec_reg;
        total_next   = total_reg;
        remain_next  = remain_reg;
        quarter_next = quarter_reg;
        skip_next    = skip_reg;
        unique case (state_reg)
            ST_IDLE:
            begin
                if (start)
                begin
                    dec_next     = dec_new;
                    skip_next    = skip_true;
                    total_next   = CYC_ONE + 2'(dec_new.changes_pc | skip_true)
                                 + 2'(dec_new.uses_indirect & ptr_msb);
                    remain_next  = total_next;
                    quarter_next = '0;
                    state_next   = ST_RUN;
                end
            end
            ST_RUN:
            begin
                quarter_next = quarter_reg + 2'h1;
                if (quarter_reg == QUARTER_LAST)
                begin
                    if (remain_reg == CYC_ONE)
                        state_next = ST_IDLE;
                    else
                        remain_next = remain_reg - 2'h1;
                end
            end
        endcase
        busy_next = state_next == ST_RUN;
        // every cycle after the first carries no work
        nop_next  = busy_next && remain_next != total_next;
    end

    always_comb
    begin
        ack_next  = wb_cyc_i && wb_stb_i && !ack_reg;
        rdat_next = '0;
        if (ack_next && !wb_we_i)
        begin
            unique case (wb_adr_i)
                ADDR_INSTR:  rdat_next[INSTR_W-1:0] = instr_reg;
                ADDR_COND:   rdat_next[COND_W-1:0]  = cond_reg;
                ADDR_DECODE:
                begin
                    rdat_next[DEC_FLAGS_LO-1:0]           = dec_reg.op;
                    rdat_next[DEC_CYC_LO-1:DEC_FLAGS_LO]  = dec_reg.flags;
                    rdat_next[DEC_SKIP_BIT-1:DEC_CYC_LO]  = total_reg;
                    rdat_next[DEC_SKIP_BIT]               = skip_reg;
                    rdat_next[DEC_IND_BIT]                = dec_reg.uses_indirect;
                end
                ADDR_STATUS: rdat_next[2:0] = {remain_reg, busy_reg};
                default:     rdat_next = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_reg   <= ST_IDLE;
            dec_reg     <= '0;
            instr_reg   <= '0;
            cond_reg    <= '0;
            total_reg   <= '0;
            remain_reg  <= '0;
            quarter_reg <= '0;
            skip_reg    <= 1'b0;
            busy_reg    <= 1'b0;
            nop_reg     <= 1'b0;
            ack_reg     <= 1'b0;
            rdat_reg    <= '0;
        end
        else
        begin
            state_reg   <= state_next;
            dec_reg     <= dec_next;
            instr_reg   <= instr_next;
            cond_reg    <= cond_next;
            total_reg   <= total_next;
            remain_reg  <= remain_next;
            quarter_reg <= quarter_next;
            skip_reg    <= skip_next;
            busy_reg    <= busy_next;
            nop_reg     <= nop_next;
            ack_reg     <= ack_next;
            rdat_reg    <= rdat_next;
        end
    end

    assign wb_dat_o    = rdat_reg;
    assign wb_ack_o    = ack_reg;
    assign dec_o       = dec_reg;
    assign busy_o      = busy_reg;
    assign nop_phase_o = nop_reg;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence one_icycle_s;
        busy_o [*4] ##1 !busy_o;
    endsequence

    sequence two_icycle_s;
        busy_o [*8] ##1 !busy_o;
    endsequence

    dec_skip_len_a: assert property (
        (start && dec_new.op == OP_DECREMENT_SKIP_ZERO && cond_next[COND_ZERO]
            && !dec_new.uses_indirect) |=> two_icycle_s)
        else $error("decrement skip did not take two cycles");
    inc_skip_short_a: assert property (
        (start && dec_new.op == OP_INCREMENT_SKIP_ZERO && !cond_next[COND_ZERO]
            && !dec_new.uses_indirect) |=> one_icycle_s)
        else $error("increment without skip not one cycle");
    bit_clear_skip_a: assert property (
        (start && dec_new.op == OP_BIT_TEST_SKIP_CLEAR)
            |=> skip_reg == !$past(cond_next[COND_BIT]))
        else $error("bit clear test skip wrong");
    bit_set_skip_a: assert property (
        (start && dec_new.op == OP_BIT_TEST_SKIP_SET) |=> skip_reg == $past(cond_next[COND_BIT]))
        else $error("bit set test skip wrong");
    sub_lit_flags_a: assert property (
        (dec_o.op == OP_SUBTRACT_FROM_LITERAL) |-> dec_o.flags == FLG_CDCZ && total_reg == CYC_ONE)
        else $error("subtract literal decode wrong");
    branch_two_a: assert property (
        (start && dec_new.changes_pc && !dec_new.uses_indirect) |=> two_icycle_s)
        else $error("pc change not two cycles");
    nop_second_a: assert property (
        $rose(busy_o) |-> !nop_phase_o ##4 (nop_phase_o == (total_reg != CYC_ONE)))
        else $error("second cycle no-op marker wrong");
    ind_extra_a: assert property (
        (start && dec_new.uses_indirect && ptr_msb && !dec_new.changes_pc && !skip_true)
            |=> total_reg == 2'h2 ##7 busy_o ##1 !busy_o)
        else $error("indirect extra cycle missing");
    quarter_pace_a: assert property (
        (busy_o && quarter_reg == QUARTER_LAST && remain_reg != CYC_ONE)
            |=> busy_o && remain_reg == $past(remain_reg) - 2'h1)
        else $error("instruction cycle not four clocks");
    wdt_flags_a: assert property (
        (dec_o.op == OP_WATCHDOG_CLEAR || dec_o.op == OP_STANDBY) |-> dec_o.flags == FLG_TO_PD)
        else $error("timeout powerdown flags not marked");

endmodule : cid_decoder

`default_nettype wire

//--- core_instruction_decode_tb.sv
/*
 * core_instruction_decode_tb: runs opcodes through the decoder over
 * Wishbone and checks the decoded op, flags and instruction-cycle length.
 * Assumes the one-cycle ack and busy timing of the decoder's hand-over.
 */
`default_nettype none

module core_instruction_decode_tb
    import cid_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              core_clk_i = 1'b0;
    logic              arst_n_i   = 1'b0;
    logic              cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [WB_AW-1:0]  adr = '0;
    logic [3:0]        sel = 4'h0;
    logic [WB_DW-1:0]  dat = '0, rdat, q;
    logic              ack, busy, nop;
    cid_dec_type       dec;
    int                mismatches = 0;
    int                tests_run  = 0;
    int                cycles     = 0;

    cid_decoder u_dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .dec_o(dec), .busy_o(busy), .nop_phase_o(nop));

    initial
    begin
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    task automatic results();
        if (mismatches == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    // a hang is cut short here, well above the few hundred cycles needed
    always @(posedge core_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            results();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (e !== g)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        // only the bench timeout ends a wait for an ack that never comes
        do
        begin
            @(posedge core_clk_i);
            n++;
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        chk("ack_wait", 2, n);
    endtask : wb

    // busy and no-op cycles are counted on clock samples, so 4 per cycle
    task automatic run(input logic [13:0] w, input logic [3:0] c, input cid_op_type op,
                       input int n, input logic [4:0] fl);
        int b;
        int p;
        b = 0;
        p = 0;
        wb(1'b1, ADDR_COND, {28'h0, c});
        wb(1'b1, ADDR_INSTR, {18'h0, w});
        do
        begin
            @(posedge core_clk_i);
            b += (busy === 1'b1);
            p += (nop === 1'b1);
        end while (busy === 1'b1 && b < 64);
        chk("op", op, dec.op);
        chk("busy_clocks", 4 * n, b);
        chk("nop_clocks", 4 * (n - 1), p);
        chk("flags", fl, dec.flags);
        wb(1'b0, ADDR_DECODE, 32'h0);
        chk("decode_cycles", n, q[11:10]);
    endtask : run

    initial
    begin
        repeat (10) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        run(14'h0B05, 4'h1, OP_DECREMENT_SKIP_ZERO, 2, FLG_NONE);
        run(14'h0B00, 4'h5, OP_DECREMENT_SKIP_ZERO, 3, FLG_NONE);
        chk("skip_taken", 1, q[12]);
        chk("indirect", 1, q[13]);
        run(14'h0F85, 4'h0, OP_INCREMENT_SKIP_ZERO, 1, FLG_NONE);
        chk("dest_file", 1, dec.dest_file);
        chk("file_addr", 32'h05, dec.file_addr);
        run(14'h1805, 4'h0, OP_BIT_TEST_SKIP_CLEAR, 2, FLG_NONE);
        run(14'h1C05, 4'h0, OP_BIT_TEST_SKIP_SET, 1, FLG_NONE);
        chk("no_skip", 0, q[12]);
        run(14'h1F85, 4'h2, OP_BIT_TEST_SKIP_SET, 2, FLG_NONE);
        chk("bit_idx", 32'h7, dec.bit_idx);
        run(14'h1C01, 4'hA, OP_BIT_TEST_SKIP_SET, 3, FLG_NONE);
        run(14'h1C05, 4'h2, OP_BIT_TEST_SKIP_SET, 2, FLG_NONE);
        run(14'h3855, 4'h0, OP_OR_LITERAL, 1, FLG_Z);
        run(14'h3C12, 4'h0, OP_SUBTRACT_FROM_LITERAL, 1, FLG_CDCZ);
        run(14'h3A12, 4'h0, OP_XOR_LITERAL, 1, FLG_Z);
        run(14'h3185, 4'h0, OP_LOAD_PC_UPPER, 1, FLG_NONE);
        run(14'h000B, 4'h0, OP_RELATIVE_BRANCH_ACC, 2, FLG_NONE);
        chk("changes_pc", 1, dec.changes_pc);
        run(14'h000A, 4'h0, OP_CALL_VIA_ACCUMULATOR, 2, FLG_NONE);
        run(14'h0009, 4'h0, OP_INTERRUPT_RETURN, 2, FLG_NONE);
        run(14'h0008, 4'h0, OP_SUBROUTINE_RETURN, 2, FLG_NONE);
        run(14'h3455, 4'h0, OP_RETURN_LITERAL, 2, FLG_NONE);
        run(14'h0064, 4'h0, OP_WATCHDOG_CLEAR, 1, FLG_TO_PD);
        run(14'h0001, 4'h0, OP_SOFT_RESET, 1, FLG_NONE);
        run(14'h0000, 4'h0, OP_NOP, 1, FLG_NONE);
        run(14'h0063, 4'h0, OP_STANDBY, 1, FLG_TO_PD);
        run(14'h0065, 4'h0, OP_DIRECTION_LOAD, 1, FLG_NONE);
        run(14'h3145, 4'h8, OP_POINTER_ADD, 1, FLG_NONE);
        chk("ptr_literal", 32'h05, dec.literal);
        chk("ptr_sel", 1, dec.ptr_sel);
        run(14'h0015, 4'h8, OP_INDIRECT_READ_MOD, 2, FLG_Z);
        chk("mod_mode", 32'h1, dec.mod_mode);
        run(14'h3F05, 4'h4, OP_INDIRECT_READ_IDX, 2, FLG_Z);
        run(14'h0019, 4'h8, OP_INDIRECT_WRITE_MOD, 1, FLG_NONE);
        run(14'h3FC5, 4'h8, OP_INDIRECT_WRITE_IDX, 2, FLG_NONE);
        run(14'h1005, 4'h0, OP_BIT_CLEAR, 1, FLG_NONE);
        run(14'h1405, 4'h0, OP_BIT_SET, 1, FLG_NONE);
        // a word written while busy must not replace the running one
        wb(1'b1, ADDR_INSTR, 32'h0000000B);
        wb(1'b1, ADDR_INSTR, 32'h00000000);
        // one edge more so a wrongly taken word would already show
        @(posedge core_clk_i);
        chk("op_while_busy", OP_RELATIVE_BRANCH_ACC, dec.op);
        wb(1'b0, ADDR_STATUS, 32'h0);
        chk("status_busy", 32'h00000003, q);
        repeat (12) @(posedge core_clk_i);
        wb(1'b0, ADDR_INSTR, 32'h0);
        chk("instr_kept", 32'h0000000B, q);
        wb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, q);
        results();
    end
endmodule : core_instruction_decode_tb

`default_nettype wire
